// >>> rtl/fopc_flash_program_control.sv
`timescale 1ns/10ps
`include "fopc_defs.svh"
// What this block does
// - Small-block bit set selects that block
// - Overlay register resets to 08, survives software standby
// - One overlay bit: redirect, protect, verify only
// - Both bits: overlay starts at interrupt with 12 V
// - Overlay pair maps RAM windows onto flash
// - Reserved bit 4 stores and reads back
// - Bit 5 drives peripheral clock halving
// - Wait mode and count go to wait controller
// - Block bits decode to fixed flash ranges
// - Pins with 12 V choose boot or user mode
// - Mode monitor bits report mode 2 or 3
// - Boot start measures low period, sets divisor
// - Calibration byte gives nine low bit times
// - After alignment send one 00 byte
// - Download to RAM F7E0 upward, then branch
// - Loader areas reserved until the branch
// - Flash mode bits enter program or erase
// - Non-blank flash erased before the download
module fopc_flash_program_control #(
  parameter int LOAD_BYTES = `FOPC_LOAD_MAX,
  parameter int DIV_W      = 20
) (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        program_voltage_pin,
  input  wire logic        mode_pin_high_12v,
  input  wire logic        mode_pin_high,
  input  wire logic        mode_pin_low,
  input  wire logic        hw_standby,
  input  wire logic        sw_standby,
  input  wire logic        irq,
  input  wire logic [15:0] cpu_addr,
  output logic             ram_redirect,
  output logic      [15:0] mapped_addr,
  output logic             flash_write_enable,
  output logic             program_mode,
  output logic             erase_mode,
  output logic             program_verify_mode,
  output logic             erase_verify_mode,
  output logic             peripheral_clock_halving,
  output logic      [1:0]  wait_mode,
  output logic      [1:0]  wait_count,
  output logic             boot_active,
  output logic             user_program_mode,
  output logic             reserved_hit,
  input  wire logic        serial_port_rxd,
  output logic             serial_port_txd,
  input  wire logic        flash_blank,
  input  wire logic        erase_done,
  output logic             erase_all_req,
  output logic             ram_wr,
  output logic      [15:0] ram_wr_addr,
  output logic      [7:0]  ram_wr_data,
  output logic             branch_req
);
  initial if (LOAD_BYTES < 1 || LOAD_BYTES > `FOPC_LOAD_MAX) $error("LOAD_BYTES out of range");
  typedef struct packed {
    logic [7:0]              ovl;
    logic [7:0]              fmc;
    logic [7:0]              lbr;
    logic [7:0]              sbr;
    logic                    ovl_live;
    logic                    boot;
    logic                    mds_low;
    fopc_pkg::fopc_boot_type bs;
    logic [DIV_W-1:0]        low_cnt;
    logic [DIV_W-1:0]        baud_divisor_register;
    logic                    kicked;
    logic [10:0]             load_cnt;
    logic                    erase_req;
    logic                    wr;
    logic [15:0]             wr_addr;
    logic [7:0]              wr_data;
    logic                    branch;
    logic [31:0]             rdata;
  } fopc_top_type;
  fopc_top_type st, next_st;
  logic       rst_meta, rst_sync;
  logic [1:0] sel;
  logic       one_set, in_win, vpp, apb_wr, tx_start, rx_valid, tx_busy;
  logic [7:0] large_hit, small_hit, rx_byte;
  logic [15:0] win_lo, win_hi, idx;
  // ****************************************
  // Reset release through two flops
  // ****************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end
  // ****************************************
  // Overlay decode and outputs
  // ****************************************
  assign vpp     = program_voltage_pin;
  assign sel     = {st.ovl[`FOPC_OVL_HI], st.ovl[`FOPC_OVL_LO]};
  assign one_set = sel == 2'b01 || sel == 2'b10;
  always_comb begin
    win_lo = `FOPC_W11_LO;
    win_hi = `FOPC_W11_HI;
    unique case (sel)
      2'b01: begin win_lo = `FOPC_W01_LO; win_hi = `FOPC_W01_HI; end
      2'b10: begin win_lo = `FOPC_W10_LO; win_hi = `FOPC_W10_HI; end
      2'b11, 2'b00: ;
    endcase
  end
  assign in_win       = cpu_addr >= win_lo && cpu_addr <= win_hi;
  // Both-bit mode stays on flash until the interrupt with 12 V present
  assign ram_redirect = in_win && (one_set || (sel == 2'b11 && st.ovl_live));
  // Same offset for reads and writes, so emulation sees its own writes
  assign mapped_addr  = ram_redirect ? cpu_addr + `FOPC_RAM_OFS : cpu_addr;
  // Emulation protect blocks program and erase but not verify
  assign program_mode        = st.fmc[`FOPC_FMC_P] && vpp && !one_set;
  assign erase_mode          = st.fmc[`FOPC_FMC_E] && vpp && !one_set;
  assign program_verify_mode = st.fmc[`FOPC_FMC_PV] && vpp;
  assign erase_verify_mode   = st.fmc[`FOPC_FMC_EV] && vpp;
  assign flash_write_enable  = (program_mode || erase_mode) && !ram_redirect
                               && |((large_hit & st.lbr) | (small_hit & st.sbr));
  assign peripheral_clock_halving = st.ovl[`FOPC_OVL_CKH];
  assign wait_mode  = st.ovl[3:2];
  assign wait_count = st.ovl[1:0];
  assign boot_active       = st.boot && st.bs != fopc_pkg::BOOT_OFF;
  assign user_program_mode = !st.boot && vpp && mode_pin_high;
  // Loader scratch areas stay locked until the branch
  assign reserved_hit = boot_active && st.bs != fopc_pkg::BOOT_RUN
    && ((cpu_addr >= `FOPC_RSV1_LO && cpu_addr <= `FOPC_RSV1_HI)
    ||  (cpu_addr >= `FOPC_RSV2_LO && cpu_addr <= `FOPC_RSV2_HI));
  assign tx_start      = st.bs == fopc_pkg::BOOT_ACK && !st.kicked;
  assign erase_all_req = st.erase_req;
  assign ram_wr        = st.wr;
  assign ram_wr_addr   = st.wr_addr;
  assign ram_wr_data   = st.wr_data;
  assign branch_req    = st.branch;
  // ****************************************
  // APB slave: zero wait, read data captured in setup
  // ****************************************
  assign idx     = paddr[17:2];
  assign apb_wr  = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign prdata  = st.rdata;
  assign pslverr = psel && penable && !(idx == `FOPC_IDX_FMC || idx == `FOPC_IDX_LBR
    || idx == `FOPC_IDX_SBR || idx == `FOPC_IDX_OVL || idx == `FOPC_IDX_MDM
    || idx == `FOPC_IDX_BST);
  fopc_block_decode u_decode (
    .addr      (cpu_addr),
    .large_hit (large_hit),
    .small_hit (small_hit)
  );
  fopc_uart #(.DIV_W(DIV_W)) u_uart (
    .sys_clk    (sys_clk),
    .rst        (!rst_sync),
    .bit_cycles (st.baud_divisor_register),
    .rx_enable  (st.bs == fopc_pkg::BOOT_SYNC || st.bs == fopc_pkg::BOOT_LOAD),
    .rxd        (serial_port_rxd),
    .tx_start   (tx_start),
    .tx_byte    (`FOPC_ACK_BYTE),
    .txd        (serial_port_txd),
    .tx_busy    (tx_busy),
    .rx_valid   (rx_valid),
    .rx_byte    (rx_byte)
  );
  // ****************************************
  // Registers and boot loader sequence
  // ****************************************
  always_comb begin
    next_st        = st;
    next_st.wr     = 1'b0;
    next_st.branch = 1'b0;
    next_st.erase_req = 1'b0;
    if (psel && !penable) begin
      unique case (idx)
        `FOPC_IDX_FMC: next_st.rdata = {24'h0, vpp, 3'h0, st.fmc[3:0]};
        `FOPC_IDX_LBR: next_st.rdata = {24'h0, st.lbr};
        `FOPC_IDX_SBR: next_st.rdata = {24'h0, st.sbr};
        `FOPC_IDX_OVL: next_st.rdata = {24'h0, st.ovl};
        `FOPC_IDX_MDM: next_st.rdata = {30'h0, 1'b1, st.mds_low};
        `FOPC_IDX_BST: next_st.rdata = {29'h0, st.ovl_live, st.bs == fopc_pkg::BOOT_RUN,
                                        st.boot};
        default:       next_st.rdata = 32'h0;
      endcase
    end
    if (apb_wr) begin
      unique case (idx)
        `FOPC_IDX_OVL: next_st.ovl = pwdata[7:0];
        `FOPC_IDX_FMC: if (vpp) next_st.fmc = {4'h0, pwdata[3:0]};
        `FOPC_IDX_LBR: if (vpp) begin
          next_st.lbr = pwdata[7:0];
          // Top large block is fixed in mode 2
          if (!st.mds_low) next_st.lbr[`FOPC_LB_TOP] = st.lbr[`FOPC_LB_TOP];
        end
        `FOPC_IDX_SBR: if (vpp) next_st.sbr = pwdata[7:0];
        default: ;
      endcase
    end
    next_st.ovl_live = sel == 2'b11 && (st.ovl_live || (irq && vpp));
    // Flash control drops without 12 V or in any standby; overlay keeps its value in software standby only
    if (!vpp || sw_standby) begin
      next_st.fmc = `FOPC_REG_CLEAR;
      next_st.lbr = `FOPC_REG_CLEAR;
      next_st.sbr = `FOPC_REG_CLEAR;
    end
    unique case (st.bs)
      fopc_pkg::BOOT_START: begin
        next_st.boot    = vpp && mode_pin_high_12v;
        next_st.mds_low = mode_pin_low;
        next_st.bs = (vpp && mode_pin_high_12v) ? fopc_pkg::BOOT_IDLE : fopc_pkg::BOOT_OFF;
      end
      fopc_pkg::BOOT_IDLE: if (serial_port_rxd) next_st.bs = fopc_pkg::BOOT_ARM;
      fopc_pkg::BOOT_ARM: if (!serial_port_rxd) begin
        next_st.bs      = fopc_pkg::BOOT_MEASURE;
        next_st.low_cnt = DIV_W'(1);
      end
      fopc_pkg::BOOT_MEASURE: begin
        if (!serial_port_rxd) begin
          next_st.low_cnt = st.low_cnt + 1'b1;
        end else begin
          // Start bit plus eight zero bits make the nine bit times
          next_st.baud_divisor_register = st.low_cnt / `FOPC_LOW_BITS;
          next_st.bs     = fopc_pkg::BOOT_ACK;
          next_st.kicked = 1'b0;
        end
      end
      fopc_pkg::BOOT_ACK: begin
        next_st.kicked = 1'b1;
        if (st.kicked && !tx_busy) next_st.bs = fopc_pkg::BOOT_SYNC;
      end
      // A wrong reply leaves the loader in BOOT_SYNC, waiting for a later 55 byte
      fopc_pkg::BOOT_SYNC: if (rx_valid && rx_byte == `FOPC_SYNC_BYTE) begin
        next_st.bs = fopc_pkg::BOOT_CHECK;
      end
      fopc_pkg::BOOT_CHECK: begin
        next_st.bs        = flash_blank ? fopc_pkg::BOOT_LOAD : fopc_pkg::BOOT_ERASE;
        next_st.erase_req = !flash_blank;
      end
      fopc_pkg::BOOT_ERASE: if (erase_done) next_st.bs = fopc_pkg::BOOT_LOAD;
      fopc_pkg::BOOT_LOAD: if (rx_valid) begin
        next_st.wr       = 1'b1;
        next_st.wr_addr  = `FOPC_LOAD_BASE + 16'(st.load_cnt);
        next_st.wr_data  = rx_byte;
        next_st.load_cnt = st.load_cnt + 11'd1;
        if (st.load_cnt == 11'(LOAD_BYTES - 1)) begin
          next_st.bs     = fopc_pkg::BOOT_RUN;
          next_st.branch = 1'b1;
        end
      end
      fopc_pkg::BOOT_OFF, fopc_pkg::BOOT_RUN: ;
      default: next_st.bs = fopc_pkg::BOOT_OFF;
    endcase
  end
  // Hardware standby resets overlay, flash control and block selects, not the boot loader state
  always_ff @(posedge sys_clk or negedge rst_sync) begin
    if (!rst_sync) begin
      st     <= '0;
      st.ovl <= `FOPC_OVL_RESET;
      st.bs  <= fopc_pkg::BOOT_START;
    end else if (hw_standby) begin
      st.ovl      <= `FOPC_OVL_RESET;
      st.fmc      <= `FOPC_REG_CLEAR;
      st.lbr      <= `FOPC_REG_CLEAR;
      st.sbr      <= `FOPC_REG_CLEAR;
      st.ovl_live <= 1'b0;
    end else begin
      st <= next_st;
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_sync);
  a_ovl_standby_reset: assert property (hw_standby |=> st.ovl == `FOPC_OVL_RESET)
    else $error("overlay register not reset by hardware standby");
  a_ovl_sw_keep: assert property (sw_standby && !hw_standby && !apb_wr
    |=> $stable(st.ovl))
    else $error("overlay register changed in software standby");
  a_emul_protect: assert property (one_set |-> !program_mode && !erase_mode)
    else $error("program or erase entered under emulation protect");
  a_armed_flash: assert property (sel == 2'b11 && !st.ovl_live |-> !ram_redirect)
    else $error("overlay active before interrupt");
  a_map_offset: assert property (ram_redirect
    |-> mapped_addr - cpu_addr == `FOPC_RAM_OFS)
    else $error("overlay offset wrong");
  // Bit 4 is reserved and goes nowhere, so it is left out of the compare
  a_wait_fields: assert property (apb_wr && idx == `FOPC_IDX_OVL && !hw_standby
    |=> {peripheral_clock_halving, wait_mode, wait_count}
        == {$past(pwdata[5]), $past(pwdata[3:0])})
    else $error("overlay register fields not passed on");
  a_small_select: assert property (apb_wr && idx == `FOPC_IDX_SBR && vpp
    && !sw_standby && !hw_standby |=> st.sbr == $past(pwdata[7:0]))
    else $error("small block select not stored");
  a_ack_sent: assert property ($rose(st.bs == fopc_pkg::BOOT_ACK)
    |-> tx_start ##1 tx_busy)
    else $error("acknowledge byte not started");
  // Pins must hold still in boot, so the pin itself is the reference
  a_mode_monitor: assert property (boot_active && psel && !penable
    && idx == `FOPC_IDX_MDM |=> prdata[1:0] == {1'b1, mode_pin_low})
    else $error("mode monitor wrong in boot");
  a_erase_first: assert property (st.bs == fopc_pkg::BOOT_CHECK && !flash_blank
    |=> erase_all_req && st.bs == fopc_pkg::BOOT_ERASE)
    else $error("erase not requested before download");
  a_branch_addr: assert property (branch_req |-> ram_wr
    && ram_wr_addr == 16'(`FOPC_LOAD_BASE + LOAD_BYTES - 1))
    else $error("branch not after last download byte");
  c_boot_sync: cover property (st.bs == fopc_pkg::BOOT_SYNC
    ##[1:1000] st.bs == fopc_pkg::BOOT_CHECK);
  c_overlay_live: cover property ($rose(st.ovl_live));
  c_branch: cover property (branch_req);
  c_program: cover property (flash_write_enable && program_mode);
endmodule

// >>> rtl/fopc_defs.svh
`ifndef FOPC_DEFS_SVH
`define FOPC_DEFS_SVH
// ****************************************
// Register indices (byte address is four times the index)
// ****************************************
`define FOPC_IDX_FMC   16'hff80
`define FOPC_IDX_LBR   16'hff82
`define FOPC_IDX_SBR   16'hff83
`define FOPC_IDX_OVL   16'hffc2
`define FOPC_IDX_MDM   16'hffc5
`define FOPC_IDX_BST   16'hffc6
// ****************************************
// Reset values and field positions
// ****************************************
`define FOPC_OVL_RESET 8'h08
`define FOPC_REG_CLEAR 8'h00
`define FOPC_OVL_HI    7
`define FOPC_OVL_LO    6
`define FOPC_OVL_CKH   5
`define FOPC_FMC_P     0
`define FOPC_FMC_E     1
`define FOPC_FMC_PV    2
`define FOPC_FMC_EV    3
`define FOPC_FMC_VPP   7
`define FOPC_LB_TOP    7
// ****************************************
// Overlay map
// ****************************************
`define FOPC_RAM_OFS   16'hf800
`define FOPC_W01_LO    16'h0080
`define FOPC_W01_HI    16'h00ff
`define FOPC_W10_LO    16'h0080
`define FOPC_W10_HI    16'h017f
`define FOPC_W11_LO    16'h0000
`define FOPC_W11_HI    16'h007f
// ****************************************
// Erase block boundaries, lowest first; block i is [b(i), b(i+1))
// ****************************************
`define FOPC_LB_BOUNDS {16'hf780, 16'hef80, 16'hc000, 16'ha000, 16'h8000, 16'h6000, \
                        16'h4000, 16'h2000, 16'h1000}
`define FOPC_SB_BOUNDS {16'h1000, 16'h0c00, 16'h0800, 16'h0400, 16'h0200, 16'h0180, \
                        16'h0100, 16'h0080, 16'h0000}
// ****************************************
// Boot loader
// ****************************************
`define FOPC_ACK_BYTE  8'h00
`define FOPC_SYNC_BYTE 8'h55
`define FOPC_LOW_BITS  20'd9
`define FOPC_LOAD_BASE 16'hf7e0
`define FOPC_LOAD_MAX  1934
`define FOPC_RSV1_LO   16'hf780
`define FOPC_RSV1_HI   16'hf7df
`define FOPC_RSV2_LO   16'hff6e
`define FOPC_RSV2_HI   16'hff7f
`endif

// >>> rtl/fopc_pkg.sv
package fopc_pkg;
  typedef enum logic [3:0] {
    BOOT_OFF, BOOT_START, BOOT_IDLE, BOOT_ARM, BOOT_MEASURE, BOOT_ACK,
    BOOT_SYNC, BOOT_CHECK, BOOT_ERASE, BOOT_LOAD, BOOT_RUN
  } fopc_boot_type;
  typedef enum logic [1:0] {
    LINE_IDLE, LINE_START, LINE_DATA, LINE_STOP
  } fopc_line_type;
endpackage

// >>> rtl/fopc_block_decode.sv
`timescale 1ns/10ps
`include "fopc_defs.svh"
// Address to erase-block decode
module fopc_block_decode (
  input  wire logic [15:0] addr,
  output logic      [7:0]  large_hit,
  output logic      [7:0]  small_hit
);
  localparam logic [143:0] LB = `FOPC_LB_BOUNDS;
  localparam logic [143:0] SB = `FOPC_SB_BOUNDS;
  // ****************************************
  // One comparator pair per block
  // ****************************************
  for (genvar i = 0; i < 8; i++) begin : g_blk
    assign large_hit[i] = addr >= LB[16*i +: 16] && addr < LB[16*(i+1) +: 16];
    assign small_hit[i] = addr >= SB[16*i +: 16] && addr < SB[16*(i+1) +: 16];
  end
endmodule

// >>> rtl/fopc_uart.sv
`timescale 1ns/10ps
// Async serial byte engine, 8N1, bit time given in cycles
module fopc_uart #(
  parameter int DIV_W = 20
) (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [DIV_W-1:0] bit_cycles,
  input  wire logic             rx_enable,
  input  wire logic             rxd,
  input  wire logic             tx_start,
  input  wire logic [7:0]       tx_byte,
  output logic                  txd,
  output logic                  tx_busy,
  output logic                  rx_valid,
  output logic      [7:0]       rx_byte
);
  initial if (DIV_W < 4) $error("DIV_W too small");
  typedef struct packed {
    fopc_pkg::fopc_line_type rs;
    logic [DIV_W-1:0]        rt;
    logic [3:0]              rn;
    logic [7:0]              rsh;
    logic                    rv;
    logic [DIV_W-1:0]        tt;
    logic [3:0]              tn;
    logic [9:0]              tsh;
  } fopc_uart_type;
  fopc_uart_type st, next_st;
  assign txd      = st.tsh[0];
  assign tx_busy  = st.tn != 4'h0;
  assign rx_valid = st.rv;
  assign rx_byte  = st.rsh;
  // ****************************************
  // Receiver samples mid-bit; transmitter shifts LSB first
  // ****************************************
  always_comb begin
    next_st    = st;
    next_st.rv = 1'b0;
    if (st.rt != '0) next_st.rt = st.rt - 1'b1;
    unique case (st.rs)
      fopc_pkg::LINE_IDLE: if (rx_enable && !rxd) begin
        next_st.rs = fopc_pkg::LINE_START;
        next_st.rt = bit_cycles >> 1;
      end
      fopc_pkg::LINE_START: if (st.rt == '0) begin
        // A glitch shorter than half a bit is not a start
        next_st.rs = rxd ? fopc_pkg::LINE_IDLE : fopc_pkg::LINE_DATA;
        next_st.rt = bit_cycles;
        next_st.rn = 4'h0;
      end
      fopc_pkg::LINE_DATA: if (st.rt == '0) begin
        next_st.rsh = {rxd, st.rsh[7:1]};
        next_st.rn  = st.rn + 4'h1;
        next_st.rt  = bit_cycles;
        if (st.rn == 4'h7) next_st.rs = fopc_pkg::LINE_STOP;
      end
      fopc_pkg::LINE_STOP: if (st.rt == '0) begin
        next_st.rs = fopc_pkg::LINE_IDLE;
        next_st.rv = rxd;
      end
    endcase
    if (st.tn == 4'h0) begin
      if (tx_start) begin
        next_st.tsh = {1'b1, tx_byte, 1'b0};
        next_st.tn  = 4'ha;
        next_st.tt  = bit_cycles;
      end
    end else if (st.tt == '0) begin
      next_st.tsh = {1'b1, st.tsh[9:1]};
      next_st.tn  = st.tn - 4'h1;
      next_st.tt  = bit_cycles;
    end else begin
      next_st.tt = st.tt - 1'b1;
    end
  end
  // Line idles high out of reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st     <= '0;
      st.tsh <= 10'h3ff;
    end else begin
      st <= next_st;
    end
  end
endmodule

// >>> verification/fopc_host_model.sv
`timescale 1ns/10ps
// ****************************************
// Host computer on the boot serial link
// ****************************************
module fopc_host_model #(
  parameter int BIT_CYC = 5208,
  parameter int NBYTES  = 4
) (
  input  wire logic       sys_clk,
  input  wire logic       go,
  input  wire logic       dev_txd,
  output logic            host_txd,
  output logic      [7:0] ack_seen,
  output logic            done
);
  // One 8N1 frame, LSB first, each bit held for a whole bit time
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      host_txd <= f[i];
      repeat (BIT_CYC) @(posedge sys_clk);
    end
  endtask
  // Calibrate, check the reply mid-bit, then answer and download
  initial begin
    host_txd = 1'b1; // Pulled-up line idles high
    ack_seen = 8'hff;
    done = 1'b0;
    @(posedge sys_clk iff go);
    // Start bit and eight zero bits give the nine low bit times
    host_txd <= 1'b0;
    repeat (9 * BIT_CYC) @(posedge sys_clk);
    // The reply starts inside our stop bit, so watch for it from here on
    host_txd <= 1'b1;
    @(negedge dev_txd);
    repeat (BIT_CYC / 2) @(posedge sys_clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge sys_clk);
      ack_seen[i] = dev_txd;
    end
    // Idle two bit times so the device has surely left its stop bit
    repeat (2 * BIT_CYC) @(posedge sys_clk);
    if (ack_seen == 8'h00) begin
      send(8'h55);
      for (int n = 0; n < NBYTES; n++) begin
        send(8'ha0 + n[7:0]); // Lands above the loader scratch area
      end
    end // A corrupted reply sends nothing more; the device keeps waiting for a 55 byte
    done = 1'b1;
  end
endmodule

// >>> verification/test_flash_onboard_program_control.sv
`timescale 1ns/10ps
`include "fopc_defs.svh"
module test_flash_onboard_program_control;
  logic        sys_clk, rst_n, psel, penable, pwrite, vpp, hv, mh, ml, hws, sws, irq, go;
  logic        fblank, edone, rxd, txd, redir, fwe, pm, pvm, halv, boot, upm, rsv;
  logic        perr, se, prdy, eraq, rwr, brq, hdone, em, evm;
  logic [17:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] caddr, maddr, rwa;
  logic [1:0]  wm, wc;
  logic [7:0]  rwd, ack;
  int          n_errors, comparisons, nwr, k;
  localparam logic [15:0] WLO [3] = '{16'h0080, 16'h0080, 16'h0000};
  localparam logic [15:0] WHI [3] = '{16'h00ff, 16'h017f, 16'h007f};
  localparam logic [15:0] BND [17] = '{16'h0000, 16'h0080, 16'h0100, 16'h0180, 16'h0200,
    16'h0400, 16'h0800, 16'h0c00, 16'h1000, 16'h2000, 16'h4000, 16'h6000, 16'h8000,
    16'ha000, 16'hc000, 16'hef80, 16'hf780};
  fopc_flash_program_control #(.LOAD_BYTES(4)) fopc_flash_program_control_i (
    .sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready(prdy),
    .pslverr(perr), .program_voltage_pin(vpp), .mode_pin_high_12v(hv), .mode_pin_high(mh),
    .mode_pin_low(ml), .hw_standby(hws), .sw_standby(sws), .irq, .cpu_addr(caddr),
    .ram_redirect(redir), .mapped_addr(maddr), .flash_write_enable(fwe), .program_mode(pm),
    .erase_mode(em), .program_verify_mode(pvm), .erase_verify_mode(evm),
    .peripheral_clock_halving(halv), .wait_mode(wm), .wait_count(wc), .boot_active(boot),
    .user_program_mode(upm), .reserved_hit(rsv), .serial_port_rxd(rxd),
    .serial_port_txd(txd), .flash_blank(fblank), .erase_done(edone), .erase_all_req(eraq),
    .ram_wr(rwr), .ram_wr_addr(rwa), .ram_wr_data(rwd), .branch_req(brq));
  // Short bit time keeps the run small; the divisor is measured, not assumed
  fopc_host_model #(.BIT_CYC(54), .NBYTES(4)) fopc_host_model_i (
    .sys_clk, .go, .dev_txd(txd), .host_txd(rxd), .ack_seen(ack), .done(hdone));
  // ****************************************
  // Clock, checks and bus tasks
  // ****************************************
  always #10 sys_clk = ~sys_clk;
  task automatic give_verdict();
    $display("TB: errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; waits for pready under a bound, then one idle edge
  task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (prdy !== 1'b1 && t < 50) begin
      t++;
      @(posedge sys_clk);
    end
    if (t == 50) begin
      n_errors++;
      give_verdict();
    end
    rd = prdata;
    se = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic probe(input logic [15:0] a, input logic e);
    caddr <= a;
    @(posedge sys_clk);
    chk("redirect", e, redir);
    chk("mapped", e ? a + 16'hf800 : a, maddr);
  endtask
  task automatic fw(input logic [15:0] a, input logic e);
    caddr <= a;
    @(posedge sys_clk);
    chk("write enable", e, fwe);
  endtask
  task automatic reset_dut(input logic b);
    rst_n <= 1'b0;
    vpp <= b;
    hv <= b;
    // Mode 3 for the normal run, so the top large block stays writable; mode 2 for boot
    ml <= !b;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    // Pins are latched at the third edge; the fourth shows the result
    repeat (4) @(posedge sys_clk);
  endtask
  task automatic bwait(ref logic s);
    k = 0;
    while (s !== 1'b1 && k < 20000) begin
      k++;
      @(posedge sys_clk);
    end
    if (k == 20000) begin
      n_errors++;
      give_verdict();
    end
  endtask
  // Download watcher: address, data and the branch with the last byte
  always @(posedge sys_clk) begin
    if (brq === 1'b1) chk("branch index", 3, nwr);
    if (rwr === 1'b1) begin
      chk("ram addr", 16'hf7e0 + nwr, rwa);
      chk("ram data", 8'ha0 + nwr, rwd);
      nwr++;
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {sys_clk, rst_n, psel, penable, pwrite, vpp, hv, mh, ml, hws, sws, irq, go} = '0;
    {fblank, edone, paddr, pwdata, caddr, n_errors, comparisons, nwr} = '0;
    reset_dut(1'b0);
    apb(1'b0, `FOPC_IDX_OVL, 8'h00);
    chk("overlay reset", 8'h08, rd);
    apb(1'b1, `FOPC_IDX_OVL, 8'h3f);
    apb(1'b0, `FOPC_IDX_OVL, 8'h00);
    chk("overlay rw", 8'h3f, rd);
    chk("clock halving", 1'b1, halv);
    chk("wait fields", 4'hf, {wm, wc});
    apb(1'b0, 16'h0000, 8'h00);
    chk("unmapped error", 1'b1, se);
    sws <= 1'b1;
    @(posedge sys_clk);
    sws <= 1'b0;
    apb(1'b0, `FOPC_IDX_OVL, 8'h00);
    chk("sw standby keeps", 8'h3f, rd);
    hws <= 1'b1;
    @(posedge sys_clk);
    hws <= 1'b0;
    apb(1'b0, `FOPC_IDX_OVL, 8'h00);
    chk("hw standby resets", 8'h08, rd);
    vpp <= 1'b1;
    mh <= 1'b1;
    ml <= 1'b1;
    apb(1'b0, `FOPC_IDX_MDM, 8'h00);
    chk("user mode", 1'b1, upm);
    chk("mode monitor 3", 2'b11, rd[1:0]);
    for (int s = 1; s < 4; s++) begin
      apb(1'b1, `FOPC_IDX_OVL, {s[1:0], 6'h08});
      if (s == 3) begin
        probe(WLO[2], 1'b0);
        irq <= 1'b1;
        @(posedge sys_clk);
        irq <= 1'b0;
      end
      probe(WLO[s - 1], 1'b1);
      probe(WHI[s - 1], 1'b1);
      probe(WHI[s - 1] + 16'h1, 1'b0);
    end
    apb(1'b1, `FOPC_IDX_OVL, 8'h48);
    apb(1'b1, `FOPC_IDX_FMC, 8'h04);
    chk("verify allowed", 1'b1, pvm);
    apb(1'b1, `FOPC_IDX_FMC, 8'h01);
    chk("program refused", 1'b0, pm);
    apb(1'b1, `FOPC_IDX_FMC, 8'h02);
    chk("erase refused", 1'b0, em);
    apb(1'b1, `FOPC_IDX_FMC, 8'h08);
    chk("erase verify allowed", 1'b1, evm);
    apb(1'b1, `FOPC_IDX_FMC, 8'h01);
    apb(1'b1, `FOPC_IDX_OVL, 8'h08);
    chk("program mode", 1'b1, pm);
    for (int j = 0; j < 16; j++) begin
      apb(1'b1, j < 8 ? `FOPC_IDX_SBR : `FOPC_IDX_LBR, 8'h01 << j[2:0]);
      fw(BND[j], 1'b1);
      fw(BND[j + 1] - 16'h1, 1'b1);
      fw(BND[j + 1], 1'b0);
      apb(1'b1, j < 8 ? `FOPC_IDX_SBR : `FOPC_IDX_LBR, 8'h00);
    end
    reset_dut(1'b1);
    chk("boot mode", 1'b1, boot);
    apb(1'b0, `FOPC_IDX_MDM, 8'h00);
    chk("mode monitor 2", 2'b10, rd[1:0]);
    probe(16'hf780, 1'b0);
    chk("reserved before", 1'b1, rsv);
    go <= 1'b1;
    bwait(eraq);
    chk("erase request", 1'b1, eraq);
    chk("alignment byte", 8'h00, ack);
    edone <= 1'b1;
    @(posedge sys_clk);
    edone <= 1'b0;
    bwait(hdone);
    repeat (200) @(posedge sys_clk);
    chk("bytes stored", 4, nwr);
    chk("reserved after", 1'b0, rsv);
    give_verdict();
  end
endmodule
